// ==== bit_transfer_core.sv ====
// Overview of operation
// - in: io byte into a working register in one cycle, flags kept
// - push: register onto stack in one cycle, flags kept
// - pop: register from stack in two cycles, flags kept
// - load_and_set: register gets old byte, memory gets register or byte
// - load_and_clear: register gets old byte, memory gets not register and byte
// - load_and_toggle: register gets old byte, memory gets register xor byte
// - rotate left through carry in one cycle, updates z c n v h
// - rotate right through carry in one cycle, updates z c n v
// - set_io_bit forces one io bit high in one cycle
// - clear_io_bit forces one io bit low in one cycle
// - store bit of source_reg into transfer flag in one cycle
// - load transfer flag into a register bit in one cycle
// - set_overflow sets v only, one cycle
// - clear_overflow clears v only, one cycle
// - set and clear half carry individually, one cycle each
// - set and clear sign flag individually, one cycle each
// - data loads from internal sram take one cycle over the listed count
// - listed counts are internal only; external accesses add wait cycles, except push, which never waits
//
// The address map and register access over AXI4-Lite were left to the implementer.
`include "cpu_ops_regs.svh"

module bit_transfer_core import cpu_ops_pkg::*; #(
    parameter int RAM_AW = 13,
    parameter int IO_AW = 6,
    parameter logic [7:0] EXT_WAIT = `EXT_WAIT_DEFAULT
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    localparam int IO_SIZE = 2**IO_AW;

    // architectural state
    logic [7:0] wreg [32];
    logic [7:0] io_space [IO_SIZE];
    status_flags_s status_flags;
    logic [15:0] sp;
    logic [15:0] zptr;
    logic [4:0] reg_sel;
    logic [IO_AW-1:0] io_sel;

    // execution control
    state_e state;
    cmd_s cmd;
    logic [7:0] wait_left;
    logic [7:0] cyc_count;
    logic [7:0] last_cycles;

    // bus bookkeeping
    logic aw_have;
    logic w_have;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_fire;
    logic wr_hit;
    logic launch;

    // datapath
    logic [7:0] rd_val;
    logic [15:0] mem_addr;
    logic is_ext;
    logic is_mem_op;
    logic [7:0] ram_rdata;
    logic ram_we;
    logic [7:0] ram_wdata;
    logic [RAM_AW-1:0] ram_waddr;
    logic [7:0] rot_res;
    logic [31:0] next_rdata;
    logic next_rerr;
    logic [31:0] wr_merged;

    assign rd_val = wreg[cmd.rd];
    assign mem_addr = (cmd.op == OP_POP) ? 16'(sp + 16'h0001) : zptr;
    // anything above internal sram is treated as the external ram window
    assign is_ext = (mem_addr >> RAM_AW) != 16'h0000;
    assign is_mem_op = cmd.op inside {OP_POP, OP_EXCHANGE_MEMORY, OP_LOAD_AND_SET,
                                      OP_LOAD_AND_CLEAR, OP_LOAD_AND_TOGGLE, OP_LOAD_Z};
    assign wr_fire = aw_have && w_have && !bvalid;
    assign launch = wr_fire && (wr_addr == `OFF_CMD) && wr_strb[0] && (state == ST_IDLE);
    assign wr_merged = {wr_strb[3] ? wr_data[31:24] : 8'h00,
                        wr_strb[2] ? wr_data[23:16] : 8'h00,
                        wr_strb[1] ? wr_data[15:8] : 8'h00,
                        wr_strb[0] ? wr_data[7:0] : 8'h00};

    always_comb begin
        wr_hit = 1'b1;
        case (wr_addr)
            `OFF_CMD, `OFF_STATUS, `OFF_FLAGS, `OFF_SP, `OFF_ZPTR,
            `OFF_REG_SEL, `OFF_REG_DATA, `OFF_IO_SEL, `OFF_IO_DATA: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // the stack and the z-addressed bytes share one data memory
    data_ram #(.AW(RAM_AW), .DW(8)) u_ram (
        .aclk(aclk),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .raddr(mem_addr[RAM_AW-1:0]),
        .rdata(ram_rdata)
    );

    always_comb begin
        ram_we = 1'b0;
        ram_waddr = mem_addr[RAM_AW-1:0];
        ram_wdata = rd_val;
        if (state == ST_EXEC && cmd.op == OP_PUSH) begin
            ram_we = 1'b1;
            ram_waddr = sp[RAM_AW-1:0];
        end else if (state == ST_MEM) begin
            case (cmd.op)
                OP_EXCHANGE_MEMORY: begin
                    ram_we = 1'b1;
                    ram_wdata = rd_val;
                end
                OP_LOAD_AND_SET: begin
                    ram_we = 1'b1;
                    ram_wdata = rd_val | ram_rdata;
                end
                OP_LOAD_AND_CLEAR: begin
                    ram_we = 1'b1;
                    ram_wdata = ~rd_val & ram_rdata;
                end
                OP_LOAD_AND_TOGGLE: begin
                    ram_we = 1'b1;
                    ram_wdata = rd_val ^ ram_rdata;
                end
                default: ram_we = 1'b0;
            endcase
        end
    end

    always_comb begin
        rot_res = rd_val;
        if (cmd.op == OP_ROTATE_LEFT_CARRY) begin
            rot_res = {rd_val[6:0], status_flags.c};
        end else if (cmd.op == OP_ROTATE_RIGHT_CARRY) begin
            rot_res = {status_flags.c, rd_val[7:1]};
        end
    end

    // sequencer: one exec cycle, then for memory ops optional wait cycles and one memory cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            cmd <= '0;
            wait_left <= 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (launch) begin
                        cmd <= cmd_s'(wr_merged);
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (!is_mem_op) begin
                        state <= ST_IDLE;
                    end else if (is_ext && EXT_WAIT != 8'h00) begin
                        wait_left <= EXT_WAIT;
                        state <= ST_WAIT;
                    end else begin
                        // registered ram read: the load costs its listed cycle plus one
                        state <= ST_MEM;
                    end
                end
                ST_WAIT: begin
                    if (wait_left == 8'h01) begin
                        state <= ST_MEM;
                    end
                    wait_left <= 8'(wait_left - 8'h01);
                end
                ST_MEM: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // busy cycle count of the command in flight, latched when it ends
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_count <= 8'h00;
            last_cycles <= 8'h00;
        end else if (state == ST_IDLE) begin
            cyc_count <= 8'h00;
        end else begin
            cyc_count <= 8'(cyc_count + 8'h01);
            if (state == ST_MEM || (state == ST_EXEC && !is_mem_op)) begin
                last_cycles <= 8'(cyc_count + 8'h01);
            end
        end
    end

    // registers, flags and io space; software may only touch them while idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 32; i++) begin
                wreg[i] <= 8'h00;
            end
            for (int j = 0; j < IO_SIZE; j++) begin
                io_space[j] <= 8'h00;
            end
            status_flags <= status_flags_s'(`FLAGS_RESET);
            sp <= `SP_RESET;
            zptr <= `ZPTR_RESET;
            reg_sel <= 5'h00;
            io_sel <= '0;
        end else if (state == ST_IDLE) begin
            if (wr_fire && wr_strb[0]) begin
                case (wr_addr)
                    `OFF_FLAGS: status_flags <= status_flags_s'(wr_data[7:0]);
                    `OFF_REG_SEL: reg_sel <= wr_data[4:0];
                    `OFF_REG_DATA: wreg[reg_sel] <= wr_data[7:0];
                    `OFF_IO_SEL: io_sel <= wr_data[IO_AW-1:0];
                    `OFF_IO_DATA: io_space[io_sel] <= wr_data[7:0];
                    `OFF_SP: sp <= {wr_strb[1] ? wr_data[15:8] : sp[15:8], wr_data[7:0]};
                    `OFF_ZPTR: zptr <= {wr_strb[1] ? wr_data[15:8] : zptr[15:8], wr_data[7:0]};
                    default: ;
                endcase
            end
        end else if (state == ST_EXEC) begin
            case (cmd.op)
                OP_IN: wreg[cmd.rd] <= io_space[cmd.io_addr[IO_AW-1:0]];
                OP_OUT: io_space[cmd.io_addr[IO_AW-1:0]] <= rd_val;
                OP_PUSH: sp <= 16'(sp - 16'h0001);
                OP_ROTATE_LEFT_CARRY: begin
                    wreg[cmd.rd] <= rot_res;
                    status_flags.c <= rd_val[7];
                    status_flags.h <= rd_val[3];
                    status_flags.n <= rot_res[7];
                    status_flags.v <= rot_res[7] ^ rd_val[7];
                    status_flags.z <= (rot_res == 8'h00);
                end
                OP_ROTATE_RIGHT_CARRY: begin
                    wreg[cmd.rd] <= rot_res;
                    status_flags.c <= rd_val[0];
                    status_flags.n <= rot_res[7];
                    status_flags.v <= rot_res[7] ^ rd_val[0];
                    status_flags.z <= (rot_res == 8'h00);
                end
                OP_SET_IO_BIT: io_space[cmd.io_addr[IO_AW-1:0]][cmd.bit_sel] <= 1'b1;
                OP_CLEAR_IO_BIT: io_space[cmd.io_addr[IO_AW-1:0]][cmd.bit_sel] <= 1'b0;
                OP_STORE_BIT_TO_TRANSFER_FLAG: status_flags.t <= rd_val[cmd.bit_sel];
                OP_LOAD_BIT_FROM_TRANSFER_FLAG: wreg[cmd.rd][cmd.bit_sel] <= status_flags.t;
                OP_SET_OVERFLOW: status_flags.v <= 1'b1;
                OP_CLEAR_OVERFLOW: status_flags.v <= 1'b0;
                OP_SET_HALF_CARRY: status_flags.h <= 1'b1;
                OP_CLEAR_HALF_CARRY: status_flags.h <= 1'b0;
                OP_SET_SIGN_FLAG: status_flags.s <= 1'b1;
                OP_CLEAR_SIGN_FLAG: status_flags.s <= 1'b0;
                default: ;
            endcase
        end else if (state == ST_MEM) begin
            // every memory operation hands the old byte back to the register
            wreg[cmd.rd] <= ram_rdata;
            if (cmd.op == OP_POP) begin
                sp <= 16'(sp + 16'h0001);
            end
        end
    end

    // axi4-lite write channels; address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            awready <= 1'b0;
            wr_addr <= 8'h00;
        end else if (awvalid && awready) begin
            aw_have <= 1'b1;
            awready <= 1'b0;
            wr_addr <= {awaddr[7:2], 2'b00};
        end else if (wr_fire) begin
            aw_have <= 1'b0;
        end else if (!aw_have && !bvalid) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have <= 1'b0;
            wready <= 1'b0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else if (wvalid && wready) begin
            w_have <= 1'b1;
            wready <= 1'b0;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end else if (wr_fire) begin
            w_have <= 1'b0;
        end else if (!w_have && !bvalid) begin
            wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `AXI_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // axi4-lite read: data registered one cycle after the address is taken
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rerr = 1'b0;
        case ({araddr[7:2], 2'b00})
            `OFF_CMD: next_rdata = 32'(cmd);
            `OFF_STATUS: begin
                next_rdata[`ST_BUSY] = (state != ST_IDLE);
                next_rdata[`ST_FLAGS_LSB +: 8] = status_flags;
                next_rdata[`ST_CYC_LSB +: 8] = last_cycles;
            end
            `OFF_FLAGS: next_rdata[7:0] = status_flags;
            `OFF_SP: next_rdata[15:0] = sp;
            `OFF_ZPTR: next_rdata[15:0] = zptr;
            `OFF_REG_SEL: next_rdata[4:0] = reg_sel;
            `OFF_REG_DATA: next_rdata[7:0] = wreg[reg_sel];
            `OFF_IO_SEL: next_rdata[IO_AW-1:0] = io_sel;
            `OFF_IO_DATA: next_rdata[7:0] = io_space[io_sel];
            default: next_rerr = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `AXI_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rerr ? `AXI_SLVERR : `AXI_OKAY;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end
endmodule

// ==== cpu_ops_regs.svh ====
`ifndef CPU_OPS_REGS_SVH
`define CPU_OPS_REGS_SVH

// register byte offsets on the axi4-lite bus
`define OFF_CMD 8'h00
`define OFF_STATUS 8'h04
`define OFF_FLAGS 8'h08
`define OFF_SP 8'h0C
`define OFF_ZPTR 8'h10
`define OFF_REG_SEL 8'h14
`define OFF_REG_DATA 8'h18
`define OFF_IO_SEL 8'h1C
`define OFF_IO_DATA 8'h20

// reset values
`define SP_RESET 16'h1FFF
`define ZPTR_RESET 16'h0000
`define FLAGS_RESET 8'h00

// status word layout
`define ST_BUSY 0
`define ST_FLAGS_LSB 8
`define ST_CYC_LSB 16

// axi responses
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

// default wait added to a memory read that leaves internal sram; a push never waits
`define EXT_WAIT_DEFAULT 8'h02

`endif

// ==== cpu_ops_pkg.sv ====
package cpu_ops_pkg;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_IN = 5'h01,
        OP_OUT = 5'h02,
        OP_PUSH = 5'h03,
        OP_POP = 5'h04,
        OP_EXCHANGE_MEMORY = 5'h05,
        OP_LOAD_AND_SET = 5'h06,
        OP_LOAD_AND_CLEAR = 5'h07,
        OP_LOAD_AND_TOGGLE = 5'h08,
        OP_ROTATE_LEFT_CARRY = 5'h09,
        OP_ROTATE_RIGHT_CARRY = 5'h0A,
        OP_SET_IO_BIT = 5'h0B,
        OP_CLEAR_IO_BIT = 5'h0C,
        OP_STORE_BIT_TO_TRANSFER_FLAG = 5'h0D,
        OP_LOAD_BIT_FROM_TRANSFER_FLAG = 5'h0E,
        OP_SET_OVERFLOW = 5'h0F,
        OP_CLEAR_OVERFLOW = 5'h10,
        OP_SET_HALF_CARRY = 5'h11,
        OP_CLEAR_HALF_CARRY = 5'h12,
        OP_SET_SIGN_FLAG = 5'h13,
        OP_CLEAR_SIGN_FLAG = 5'h14,
        OP_LOAD_Z = 5'h15
    } op_e;

    // gray along idle -> exec -> wait -> mem -> idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_WAIT = 2'b11,
        ST_MEM = 2'b10
    } state_e;

    // command word as written to the command register
    typedef struct packed {
        logic [1:0] spare_hi;
        logic [5:0] io_addr;
        logic [4:0] spare_mid;
        logic [2:0] bit_sel;
        logic [2:0] spare_lo;
        logic [4:0] rd;
        logic [2:0] spare_op;
        op_e op;
    } cmd_s;

    typedef struct packed {
        logic i;
        logic t;
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } status_flags_s;

endpackage

// ==== data_ram.sv ====
module data_ram #(
    parameter int AW = 13,
    parameter int DW = 8
) (
    // clock
    input wire logic aclk,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read port, data one cycle after the address
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // old data on a same-address collision; the core never needs the new value
    always_ff @(posedge aclk) begin
        rdata <= mem[raddr];
    end
endmodule

// ==== bit_transfer_core_properties.sv ====
module bit_transfer_core_properties (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    // read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response changed before bready");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data changed before rready");
    b_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("no write response after address and data");
    r_answer_a: assert property (arvalid && arready |-> ##[1:2] rvalid)
        else $error("no read data after address");
    b_close_a: assert property (bvalid && bready |=> !bvalid ##1 (awready && wready))
        else $error("write channel not reopened after response");
    r_close_a: assert property (rvalid && rready |=> !rvalid ##1 arready)
        else $error("read channel not reopened after response");
    aw_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while response pending");
    ar_block_a: assert property (rvalid |-> !arready)
        else $error("read accepted while data pending");
    bad_rd_a: assert property (arvalid && arready && araddr[7:2] > 6'h08
        |-> ##[1:2] (rvalid && rresp == 2'b10)) else $error("unmapped read not refused");
    ok_rd_a: assert property (arvalid && arready && araddr[7:2] <= 6'h08
        |-> ##[1:2] (rvalid && rresp == 2'b00)) else $error("mapped read refused");
endmodule

bind bit_transfer_core bit_transfer_core_properties u_props (.aclk, .aresetn, .awvalid,
    .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);

// ==== bit_transfer_core_tb.sv ====
`include "cpu_ops_regs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

module bit_transfer_core_tb import cpu_ops_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, q;
    logic [7:0] mem_m [8];
    logic [31:0] s;
    int n_mismatch, cmp_count, seed;

    bit_transfer_core DUT (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready);

    initial begin
        aclk = 0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] dt);
        awaddr <= a;
        wdata <= dt;
        awvalid <= 1;
        wvalid <= 1;
        fork
            begin do @(posedge aclk); while (!awready); awvalid <= 0; end
            begin do @(posedge aclk); while (!wready); wvalid <= 0; end
        join
        bready <= 1;
        do @(posedge aclk); while (!bvalid);
        q = bresp;
        bready <= 0;
    endtask

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        rready <= 1;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        q = rresp;
        rready <= 0;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // memory byte left behind by the four read-modify-write commands
    function automatic logic [7:0] rmw_result(input logic [4:0] o, input logic [7:0] v,
        input logic [7:0] m);
        case (o)
            OP_EXCHANGE_MEMORY: rmw_result = v;
            OP_LOAD_AND_SET: rmw_result = v | m;
            OP_LOAD_AND_CLEAR: rmw_result = ~v & m;
            default: rmw_result = v ^ m;
        endcase
    endfunction

    // loads a random state, runs one command and compares against the model
    task automatic one(input logic [4:0] o, input logic [15:0] spv, input logic [15:0] zv);
        logic [4:0] r;
        logic [2:0] b;
        logic [5:0] a;
        logic [7:0] v, iv, ev, eio, mz, cyc;
        logic [15:0] esp;
        status_flags_s f;
        logic ext;
        r = 5'($random(seed));
        b = 3'($random(seed));
        a = 6'($random(seed));
        v = 8'($random(seed));
        iv = 8'($random(seed));
        f = 8'($random(seed));
        ext = zv >= 16'h2000;
        mz = mem_m[zv[2:0]];
        wr(`OFF_REG_SEL, 32'(r));
        wr(`OFF_REG_DATA, 32'(v));
        wr(`OFF_IO_SEL, 32'(a));
        wr(`OFF_IO_DATA, 32'(iv));
        wr(`OFF_FLAGS, 32'(f));
        wr(`OFF_SP, 32'(spv));
        wr(`OFF_ZPTR, 32'(zv));
        wr(`OFF_CMD, {2'b0, a, 5'b0, b, 3'b0, r, 3'b0, o});
        if (ext) begin
            // external wait keeps the command running past the next read
            rd(`OFF_STATUS);
            `CHK(d[0], 1'b1)
        end
        do rd(`OFF_STATUS); while (d[0] !== 1'b0);
        ev = v;
        eio = iv;
        esp = spv;
        cyc = 8'h01;
        case (o)
            OP_IN: ev = iv;
            OP_OUT: eio = v;
            OP_PUSH: begin mem_m[spv[2:0]] = v; esp = spv - 16'h0001; end
            OP_POP: begin ev = mem_m[spv[2:0] + 3'd1]; esp = spv + 16'h0001; cyc = 8'h02; end
            OP_EXCHANGE_MEMORY, OP_LOAD_AND_SET, OP_LOAD_AND_CLEAR, OP_LOAD_AND_TOGGLE: begin
                ev = mz;
                cyc = 8'h02;
                mem_m[zv[2:0]] = rmw_result(o, v, mz);
            end
            OP_ROTATE_LEFT_CARRY: begin ev = {v[6:0], f.c}; f.c = v[7]; f.h = v[3]; end
            OP_ROTATE_RIGHT_CARRY: begin ev = {f.c, v[7:1]}; f.c = v[0]; end
            OP_SET_IO_BIT: eio[b] = 1'b1;
            OP_CLEAR_IO_BIT: eio[b] = 1'b0;
            OP_STORE_BIT_TO_TRANSFER_FLAG: f.t = v[b];
            OP_LOAD_BIT_FROM_TRANSFER_FLAG: ev[b] = f.t;
            OP_SET_OVERFLOW: f.v = 1'b1;
            OP_CLEAR_OVERFLOW: f.v = 1'b0;
            OP_SET_HALF_CARRY: f.h = 1'b1;
            OP_CLEAR_HALF_CARRY: f.h = 1'b0;
            OP_SET_SIGN_FLAG: f.s = 1'b1;
            OP_CLEAR_SIGN_FLAG: f.s = 1'b0;
            OP_LOAD_Z: begin ev = mz; cyc = ext ? 8'(8'h02 + `EXT_WAIT_DEFAULT) : 8'h02; end
            default: ;
        endcase
        if (o == OP_ROTATE_LEFT_CARRY || o == OP_ROTATE_RIGHT_CARRY) begin
            f.z = (ev == 8'h00);
            f.n = ev[7];
            f.v = ev[7] ^ f.c;
        end
        `CHK(d[23:16], cyc)
        `CHK(d[15:8], f)
        rd(`OFF_REG_DATA);
        if (!ext) `CHK(d[7:0], ev)
        rd(`OFF_IO_DATA);
        `CHK(d[7:0], eio)
        rd(`OFF_SP);
        `CHK(d[15:0], esp)
    endtask

    initial begin
        seed = 26;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, awprot, arprot, wdata} = '0;
        wstrb = 4'hF;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(`OFF_SP);
        `CHK(d, 32'(`SP_RESET))
        rd(8'h40);
        `CHK(q, 2'b10)
        wr(8'h44, 32'h0000_00FF);
        `CHK(q, 2'b10)
        $display("test bus done");
        for (int i = 0; i < 8; i++) one(OP_PUSH, 16'h0107 - 16'(i), 16'h0100);
        for (int i = 0; i < 23; i++) one((i == 22) ? 5'h1F : 5'(i), 16'h0103, 16'h0105);
        $display("test directed done");
        for (int i = 0; i < 150; i++) begin
            s = $random(seed);
            one(5'($unsigned($random(seed)) % 23), 16'h0100 + 16'(s[2:0] % 3'd7),
                16'h0100 + 16'(s[5:3]));
        end
        $display("test random done");
        one(OP_LOAD_Z, 16'h0100, 16'h2000);
        $display("test external done");
        give_verdict();
    end

    // about 180 commands of well under 100 cycles each, with wide margin
    initial begin
        repeat (60000) @(posedge aclk);
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end
endmodule
